/* logic/battery_charge_accumulator.sv */
/*
 * Digital part of a battery charge accumulator: prescaler, signed charge counter,
 * control and scaler registers, fault latch with two 1 s debouncers.
 * Assumes a register port decoded by the serial front end on clk, and analog
 * converter, comparator and detect levels that arrive asynchronously.
 */
`timescale 1ns/1ps
`include "cc_cfg.svh"

module battery_charge_accumulator #(
   parameter int DEBOUNCE_CYCLES = `CC_DEBOUNCE_CYCLES
) (
   input  wire logic             clk,
   input  wire logic             rst,
   // register port
   input  wire cc_pkg::reg_req_t reg_req,
   output logic [23:0]           reg_rdata,
   output logic                  reg_rvalid,
   // converter and detect levels
   input  wire logic             conv_pulse,
   input  wire logic             conv_up,
   input  wire logic             uv_below,
   input  wire logic             battery_detect_sense,
   // analog front end controls
   output logic                  integ_short,
   output logic                  dither_on,
   output logic                  correction_on
);
   import cc_pkg::*;

   localparam int RST_MAX = `CC_RST_CYCLES;

   cc_ctrl_t            ctrl_ff;
   logic [14:0]         count_scaler_ff;
   logic signed [15:0]  charge_count_value_ff;
   logic signed [15:0]  pre_ff;
   logic                counter_fault_flag_ff;
   rst_state_t          rst_state_ff;
   logic [15:0]         rst_cnt_ff;
   logic [2:0]          conv_sync_ff;
   logic [1:0]          dir_sync_ff;
   logic [1:0]          uv_sync_ff;
   logic [1:0]          bd_sync_ff;
   logic [31:0]         uv_deb_ff;
   logic [31:0]         bd_deb_ff;
   logic [23:0]         rdata_ff;
   logic                rvalid_ff;
   logic                short_ff;
   logic                dith_ff;
   logic                corr_ff;

   logic                wr_ctrl;
   logic                wr_scl;
   logic                conv_evt;
   logic                accum_en;
   logic signed [15:0]  nxt_pre;
   logic signed [15:0]  eff_scl;
   logic                step_up;
   logic                step_dn;
   logic signed [15:0]  nxt_count;
   logic                uv_fault;
   logic                bd_fault;

   function automatic logic [31:0] deb_next(input logic cond, input logic [31:0] cnt);
      if (!cond) begin
         return 32'h0000_0000;
      end
      if (cnt >= 32'(DEBOUNCE_CYCLES)) begin
         return cnt;
      end
      return cnt + 32'h0000_0001;
   endfunction

   function automatic logic [23:0] ctrl_view(input cc_ctrl_t c, input logic f,
                                            input logic b, input logic [15:0] v);
      logic [23:0] r;
      r = '0;
      r[`CC_CNT_MSB:`CC_CNT_LSB] = v;
      r[`CC_BIT_RST]   = b;
      r[`CC_BIT_RUN]   = c.run;
      r[`CC_BIT_CDIS]  = c.corr_dis;
      r[`CC_BIT_CAL]   = c.cal;
      r[`CC_BIT_DITH]  = c.dither;
      r[`CC_BIT_FAULT] = f;
      return r;
   endfunction

   assign wr_ctrl  = reg_req.wr && (reg_req.addr == `CC_ADDR_CTRL);
   assign wr_scl   = reg_req.wr && (reg_req.addr == `CC_ADDR_SCALER);
   assign conv_evt = conv_sync_ff[1] && !conv_sync_ff[2];
   assign accum_en = ctrl_ff.run && (rst_state_ff == ST_IDLE);
   assign eff_scl  = (count_scaler_ff == 15'h0000) ? 16'sh0001 : signed'({1'b0, count_scaler_ff});

   always_comb begin
      nxt_pre = pre_ff;
      step_up = 1'b0;
      step_dn = 1'b0;
      if (accum_en && conv_evt) begin
         nxt_pre = dir_sync_ff[1] ? pre_ff + 16'sh0001 : pre_ff - 16'sh0001;
         if (nxt_pre >= eff_scl) begin
            step_up = 1'b1;
            nxt_pre = 16'sh0000;
         end else if (nxt_pre <= -eff_scl) begin
            step_dn = 1'b1;
            nxt_pre = 16'sh0000;
         end
      end
   end

   always_comb begin
      nxt_count = charge_count_value_ff;
      if (step_up) begin
         nxt_count = charge_count_value_ff + 16'sh0001;
      end else if (step_dn) begin
         nxt_count = charge_count_value_ff - 16'sh0001;
      end
   end

   assign uv_fault = (uv_deb_ff == 32'(DEBOUNCE_CYCLES) - 32'h0000_0001) && uv_sync_ff[1];
   assign bd_fault = (bd_deb_ff == 32'(DEBOUNCE_CYCLES) - 32'h0000_0001) && bd_sync_ff[1];

   // synchronisers for asynchronous levels
   always_ff @(posedge clk) begin
      if (rst) begin
         conv_sync_ff <= 3'h0;
         dir_sync_ff  <= 2'h0;
         uv_sync_ff   <= 2'h0;
         bd_sync_ff   <= 2'h0;
      end else begin
         conv_sync_ff <= {conv_sync_ff[1:0], conv_pulse};
         dir_sync_ff  <= {dir_sync_ff[0], conv_up};
         uv_sync_ff   <= {uv_sync_ff[0], uv_below};
         bd_sync_ff   <= {bd_sync_ff[0], battery_detect_sense};
      end
   end

   // control and scaler registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_ff         <= '0;
         count_scaler_ff <= `CC_SCALER_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff.run      <= reg_req.wdata[`CC_BIT_RUN];
            ctrl_ff.corr_dis <= reg_req.wdata[`CC_BIT_CDIS];
            ctrl_ff.cal      <= reg_req.wdata[`CC_BIT_CAL];
            ctrl_ff.dither   <= reg_req.wdata[`CC_BIT_DITH];
         end
         if (wr_scl) begin
            count_scaler_ff <= reg_req.wdata[`CC_SCL_MSB:0];
         end
      end
   end

   // accumulator reset sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         rst_state_ff <= ST_IDLE;
         rst_cnt_ff   <= 16'h0000;
      end else begin
         case (rst_state_ff)
            ST_IDLE: begin
               if (wr_ctrl && reg_req.wdata[`CC_BIT_RST]) begin
                  rst_state_ff <= ST_CLEAR;
                  rst_cnt_ff   <= 16'h0000;
               end
            end
            ST_CLEAR: begin
               rst_cnt_ff <= rst_cnt_ff + 16'h0001;
               if (rst_cnt_ff >= 16'(RST_MAX - 1)) begin
                  rst_state_ff <= ST_IDLE;
               end
            end
            default: begin
               rst_state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // prescaler and charge counter
   always_ff @(posedge clk) begin
      if (rst || rst_state_ff == ST_CLEAR) begin
         pre_ff                <= 16'sh0000;
         charge_count_value_ff <= 16'sh0000;
      end else begin
         pre_ff                <= nxt_pre;
         charge_count_value_ff <= nxt_count;
      end
   end

   // debouncers for battery removal
   always_ff @(posedge clk) begin
      if (rst) begin
         uv_deb_ff <= 32'h0000_0000;
         bd_deb_ff <= 32'h0000_0000;
      end else begin
         uv_deb_ff <= deb_next(uv_sync_ff[1], uv_deb_ff);
         bd_deb_ff <= deb_next(bd_sync_ff[1], bd_deb_ff);
      end
   end

   // fault latch: a setting event wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         counter_fault_flag_ff <= 1'b0;
      end else if ((step_up || step_dn) && nxt_count == `CC_ROLL_VALUE) begin
         counter_fault_flag_ff <= 1'b1;
      end else if (uv_fault || bd_fault) begin
         counter_fault_flag_ff <= 1'b1;
      end else if (wr_ctrl && reg_req.wdata[`CC_BIT_FAULT]) begin
         counter_fault_flag_ff <= 1'b0;
      end
   end

   // read data; a control write echoes the live counter
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_ff  <= 24'h00_0000;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= 1'b0;
         if (wr_ctrl || (reg_req.rd && reg_req.addr == `CC_ADDR_CTRL)) begin
            rdata_ff  <= ctrl_view(ctrl_ff, counter_fault_flag_ff,
                                   rst_state_ff == ST_CLEAR, charge_count_value_ff);
            rvalid_ff <= 1'b1;
         end else if (reg_req.rd && reg_req.addr == `CC_ADDR_SCALER) begin
            rdata_ff  <= {9'h000, count_scaler_ff};
            rvalid_ff <= 1'b1;
         end else if (reg_req.rd) begin
            rdata_ff  <= 24'h00_0000;
            rvalid_ff <= 1'b1;
         end
      end
   end

   // analog front end controls
   always_ff @(posedge clk) begin
      if (rst) begin
         short_ff <= 1'b0;
         dith_ff  <= 1'b0;
         corr_ff  <= 1'b1;
      end else begin
         short_ff <= ctrl_ff.cal;
         dith_ff  <= ctrl_ff.dither && !ctrl_ff.corr_dis;
         corr_ff  <= !ctrl_ff.corr_dis;
      end
   end

   assign reg_rdata     = rdata_ff;
   assign reg_rvalid    = rvalid_ff;
   assign integ_short   = short_ff;
   assign dither_on     = dith_ff;
   assign correction_on = corr_ff;

   chk_roll_sets_fault: assert property (@(posedge clk) disable iff (rst)
      (step_up || step_dn) && nxt_count == `CC_ROLL_VALUE && rst_state_ff == ST_IDLE
      |=> counter_fault_flag_ff && charge_count_value_ff == `CC_ROLL_VALUE)
      else $error("roll-over did not set the fault flag");

   chk_fault_stays_latched: assert property (@(posedge clk) disable iff (rst)
      counter_fault_flag_ff && !(wr_ctrl && reg_req.wdata[`CC_BIT_FAULT])
      |=> counter_fault_flag_ff)
      else $error("fault flag dropped without a software clear");

   chk_reset_clears_count: assert property (@(posedge clk) disable iff (rst)
      wr_ctrl && reg_req.wdata[`CC_BIT_RST] && rst_state_ff == ST_IDLE
      |=> ##1 charge_count_value_ff == 16'sh0000 && pre_ff == 16'sh0000)
      else $error("accumulator reset did not clear the counter");

   chk_reset_ends_bound: assert property (@(posedge clk) disable iff (rst)
      $rose(rst_state_ff == ST_CLEAR) |-> ##[1:RST_MAX] rst_state_ff == ST_IDLE)
      else $error("reset period exceeded its limit");

   chk_stopped_holds: assert property (@(posedge clk) disable iff (rst)
      !ctrl_ff.run && rst_state_ff == ST_IDLE && !$past(rst_state_ff == ST_CLEAR)
      |=> $stable(charge_count_value_ff) && $stable(pre_ff))
      else $error("counter moved while stopped");

   chk_one_step_only: assert property (@(posedge clk) disable iff (rst)
      rst_state_ff == ST_IDLE && $past(rst_state_ff) == ST_IDLE
      |-> charge_count_value_ff - $past(charge_count_value_ff) inside {-16'sh1, 16'sh0, 16'sh1})
      else $error("counter moved by more than one step");

   chk_dither_gated: assert property (@(posedge clk) disable iff (rst)
      dither_on |-> correction_on && $past(ctrl_ff.dither))
      else $error("dither active with correction disabled");

   chk_scaler_default: assert property (@(posedge clk)
      $past(rst) |-> count_scaler_ff == `CC_SCALER_RESET)
      else $error("scaler not one after reset");

   chk_write_echoes_count: assert property (@(posedge clk) disable iff (rst)
      wr_ctrl |=> reg_rvalid && reg_rdata[`CC_CNT_MSB:`CC_CNT_LSB] == $past(charge_count_value_ff))
      else $error("control write did not return the counter");

   chk_debounce_restart: assert property (@(posedge clk) disable iff (rst)
      !uv_sync_ff[1] |=> uv_deb_ff == 32'h0000_0000)
      else $error("undervoltage debounce did not restart");

   chk_short_follows_cal: assert property (@(posedge clk) disable iff (rst)
      ctrl_ff.cal |=> integ_short)
      else $error("integrator short does not follow calibration bit");

   chk_detect_restart: assert property (@(posedge clk) disable iff (rst)
      !bd_sync_ff[1] |=> bd_deb_ff == 32'h0000_0000)
      else $error("battery-detect debounce did not restart");

   chk_long_low_faults: assert property (@(posedge clk) disable iff (rst)
      (uv_deb_ff == 32'(DEBOUNCE_CYCLES) - 32'h0000_0001 && uv_sync_ff[1])
      || (bd_deb_ff == 32'(DEBOUNCE_CYCLES) - 32'h0000_0001 && bd_sync_ff[1])
      |=> counter_fault_flag_ff)
      else $error("debounced fault did not set the flag");

   chk_fault_has_cause: assert property (@(posedge clk) disable iff (rst)
      $rose(counter_fault_flag_ff)
      |-> $past(uv_fault || bd_fault || ((step_up || step_dn) && nxt_count == `CC_ROLL_VALUE)))
      else $error("fault flag set without a covered fault");

   chk_run_steps_count: assert property (@(posedge clk) disable iff (rst)
      accum_en && conv_evt && pre_ff == 16'sh0000 && count_scaler_ff == `CC_SCALER_RESET
      |=> charge_count_value_ff == $past(charge_count_value_ff)
          + ($past(dir_sync_ff[1]) ? 16'sh0001 : 16'shffff))
      else $error("count did not step once per count at unit scale");
endmodule

/* logic/cc_cfg.svh */
/*
 * Addresses, field positions, reset values and timing counts of the charge accumulator.
 * Assumes a 100 ns system clock and is included by its bare name.
 */
`ifndef CC_CFG_SVH
`define CC_CFG_SVH
`define CC_ADDR_CTRL        4'h9
`define CC_ADDR_SCALER      4'ha
`define CC_BIT_RST          0
`define CC_BIT_RUN          1
`define CC_BIT_CDIS         2
`define CC_BIT_CAL          3
`define CC_BIT_DITH         4
`define CC_BIT_FAULT        5
`define CC_CNT_LSB          8
`define CC_CNT_MSB          23
`define CC_SCL_MSB          14
`define CC_SCALER_RESET     15'h0001
`define CC_ROLL_VALUE       16'h8000
`define CC_CLK_PERIOD_NS    100
`define CC_RST_TIME_NS      40000
// longest time: rounds down
`define CC_RST_CYCLES       (`CC_RST_TIME_NS / `CC_CLK_PERIOD_NS)
`define CC_DEBOUNCE_TIME_MS 1000
// least time: exact here, 10,000,000 cycles
`define CC_DEBOUNCE_CYCLES  ((`CC_DEBOUNCE_TIME_MS * 1000000) / `CC_CLK_PERIOD_NS)
`endif

/* logic/cc_pkg.sv */
/*
 * Types shared by the charge accumulator and its bench.
 * Assumes the constants of cc_cfg.svh.
 */
package cc_pkg;
   typedef struct packed {
      logic dither;
      logic cal;
      logic corr_dis;
      logic run;
   } cc_ctrl_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [23:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef enum {ST_IDLE, ST_CLEAR} rst_state_t;
endpackage

/* verif/cc_host_model.sv */
/*
 * Host processor model: issues register accesses on the parallel register port.
 * Assumes a 100 ns clk and one-cycle wr/rd strobes taken at a rising edge.
 */
`timescale 1ns/1ps

module cc_host_model (
   // clock
   input  wire logic             clk,
   // register port
   output cc_pkg::reg_req_t      reg_req,
   input  wire logic [23:0]      reg_rdata,
   input  wire logic             reg_rvalid
);
   import cc_pkg::*;

   initial begin
      reg_req = '0;
   end

   // one access; ok tells whether the answer strobe matched what was expected
   task automatic access(input logic w, input logic [3:0] a, input logic [23:0] d,
                         input logic ans, output logic [23:0] q, output logic ok);
      @(posedge clk);
      #10;
      reg_req.addr  = a;
      reg_req.wdata = d;
      reg_req.wr    = w;
      reg_req.rd    = !w;
      @(posedge clk);
      #10;
      reg_req.wr    = 1'b0;
      reg_req.rd    = 1'b0;
      // released lines show no stale value
      reg_req.addr  = ~a;
      reg_req.wdata = ~d;
      ok = (reg_rvalid === ans);
      q  = reg_rdata;
   endtask
endmodule

/* verif/test_battery_charge_accumulator.sv */
/*
 * Self-checking bench of the charge accumulator: register tasks, converter bursts,
 * fault sources. Assumes cc_cfg.svh and a shortened debounce of 50 cycles.
 */
`timescale 1ns/1ps
`include "cc_cfg.svh"

module test_battery_charge_accumulator;
   import cc_pkg::*;

   logic             clk;
   logic             rst;
   reg_req_t         reg_req;
   logic [23:0]      reg_rdata;
   logic             reg_rvalid;
   logic             conv_pulse;
   logic             conv_up;
   logic             uv_below;
   logic             battery_detect_sense;
   logic             integ_short;
   logic             dither_on;
   logic             correction_on;
   int               err_count;
   int               total_checks;

   battery_charge_accumulator #(.DEBOUNCE_CYCLES(50)) dut (
      .clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .conv_pulse(conv_pulse), .conv_up(conv_up),
      .uv_below(uv_below), .battery_detect_sense(battery_detect_sense),
      .integ_short(integ_short), .dither_on(dither_on), .correction_on(correction_on));

   cc_host_model host (
      .clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   task automatic check(input logic [23:0] g, input logic [23:0] e);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask

`define CHK(g, e) check(24'(g), 24'(e))

   task automatic conclude();
      if (err_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // control word as read back: count, fault, dither, cal, corr disable, run, busy
   function automatic logic [23:0] ctl(input logic [15:0] c, input logic [5:0] b);
      return {c, 2'b00, b};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask

   task automatic wr(input logic [3:0] a, input logic [23:0] d, input logic [23:0] echo);
      logic [23:0] q;
      logic        ok;
      host.access(1'b1, a, d, a == `CC_ADDR_CTRL, q, ok);
      `CHK(ok, 1'b1);
      if (a == `CC_ADDR_CTRL) begin
         `CHK(q, echo);
      end
   endtask

   task automatic rd(input logic [3:0] a, input logic [23:0] e);
      logic [23:0] q;
      logic        ok;
      host.access(1'b0, a, 24'h000000, 1'b1, q, ok);
      `CHK(ok, 1'b1);
      `CHK(q, e);
   endtask

   // converter bursts: one count per two cycles, direction held through the burst
   task automatic pulses(input logic up, input int n);
      conv_up = up;
      tick(3);
      repeat (n) begin
         conv_pulse = 1'b1;
         tick(1);
         conv_pulse = 1'b0;
         tick(1);
      end
      tick(4);
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      #(100 * 80000);
      err_count++;
      conclude();
   end

   initial begin
      err_count = 0;
      total_checks = 0;
      rst = 1'b1;
      conv_pulse = 1'b0;
      conv_up = 1'b0;
      uv_below = 1'b0;
      battery_detect_sense = 1'b0;
      repeat (5) @(posedge clk);
      #10;
      rst = 1'b0;
      rd(`CC_ADDR_CTRL, 24'h000000);
      rd(`CC_ADDR_SCALER, 24'h000001);
      `CHK(correction_on, 1'b1);
      rd(4'h3, 24'h000000);
      wr(4'h3, 24'hffffff, 24'h000000);
      wr(`CC_ADDR_CTRL, 24'h00001b, ctl(16'h0000, 6'h00));
      rd(`CC_ADDR_CTRL, ctl(16'h0000, 6'h1b));
      `CHK({integ_short, dither_on, correction_on}, 3'b111);
      tick(`CC_RST_CYCLES);
      rd(`CC_ADDR_CTRL, ctl(16'h0000, 6'h1a));
      pulses(1'b1, 5);
      rd(`CC_ADDR_CTRL, ctl(16'h0005, 6'h1a));
      wr(`CC_ADDR_SCALER, 24'h000003, 24'h0);
      rd(`CC_ADDR_SCALER, 24'h000003);
      pulses(1'b0, 6);
      pulses(1'b0, 2);
      rd(`CC_ADDR_CTRL, ctl(16'h0003, 6'h1a));
      wr(`CC_ADDR_CTRL, 24'h000018, ctl(16'h0003, 6'h1a));
      pulses(1'b0, 3);
      rd(`CC_ADDR_CTRL, ctl(16'h0003, 6'h18));
      wr(`CC_ADDR_CTRL, 24'h00001a, ctl(16'h0003, 6'h18));
      pulses(1'b0, 1);
      rd(`CC_ADDR_CTRL, ctl(16'h0002, 6'h1a));
      pulses(1'b0, 1);
      wr(`CC_ADDR_CTRL, 24'h000013, ctl(16'h0002, 6'h1a));
      tick(1);
      `CHK(integ_short, 1'b0);
      tick(`CC_RST_CYCLES);
      pulses(1'b0, 2);
      rd(`CC_ADDR_CTRL, ctl(16'h0000, 6'h12));
      pulses(1'b0, 1);
      rd(`CC_ADDR_CTRL, ctl(16'hffff, 6'h12));
      wr(`CC_ADDR_SCALER, 24'h000001, 24'h0);
      pulses(1'b0, 32767);
      rd(`CC_ADDR_CTRL, ctl(16'h8000, 6'h32));
      pulses(1'b0, 1);
      rd(`CC_ADDR_CTRL, ctl(16'h7fff, 6'h32));
      wr(`CC_ADDR_CTRL, 24'h000032, ctl(16'h7fff, 6'h32));
      rd(`CC_ADDR_CTRL, ctl(16'h7fff, 6'h12));
      wr(`CC_ADDR_CTRL, 24'h000016, ctl(16'h7fff, 6'h12));
      tick(1);
      `CHK({dither_on, correction_on}, 2'b00);
      uv_below = 1'b1;
      tick(40);
      uv_below = 1'b0;
      tick(5);
      rd(`CC_ADDR_CTRL, ctl(16'h7fff, 6'h16));
      uv_below = 1'b1;
      tick(60);
      uv_below = 1'b0;
      rd(`CC_ADDR_CTRL, ctl(16'h7fff, 6'h36));
      wr(`CC_ADDR_CTRL, 24'h000036, ctl(16'h7fff, 6'h36));
      battery_detect_sense = 1'b1;
      tick(60);
      battery_detect_sense = 1'b0;
      rd(`CC_ADDR_CTRL, ctl(16'h7fff, 6'h36));
      conclude();
   end
endmodule
